// File: rtl/wpt_pkg.sv
// Constants and types shared by the power transmitter design
package wpt_pkg;
    // System clock
    localparam int CLK_HZ = 10_000_000;
    // Drive frequency band, Hz
    localparam int F_MIN_HZ = 110_000;
    localparam int F_MAX_HZ = 205_000;
    // Half-period bounds in cycles: lowest freq rounds down, highest rounds up
    localparam int HP_MAX_I = CLK_HZ / (2 * F_MIN_HZ);
    localparam int HP_MIN_I = (CLK_HZ + 2 * F_MAX_HZ - 1) / (2 * F_MAX_HZ);
    localparam logic [6:0] HP_MAX = 7'(HP_MAX_I);
    localparam logic [6:0] HP_MIN = 7'(HP_MIN_I);
    localparam logic [6:0] HP_RESET = HP_MAX;
    // Largest on-time trim once the band top is reached
    localparam logic [6:0] TRIM_MAX = 7'h14;
    localparam logic [6:0] TRIM_RESET = 7'h00;
    // Limiter step interval
    localparam int LIMIT_STEP_US = 400;
    localparam int LIMIT_STEP_CYC = LIMIT_STEP_US * (CLK_HZ / 1_000_000);
    // LED blink periods (figures as printed)
    localparam int SLOW_BLINK_MS = 1600;
    localparam int FAST_BLINK_MS = 400;
    localparam int FAST_HALF_CYC = (FAST_BLINK_MS / 2) * (CLK_HZ / 1000);
    localparam int SLOW_PER_FAST = SLOW_BLINK_MS / FAST_BLINK_MS;
    // Packet framing
    localparam logic [4:0] PREAMBLE_MIN = 5'h0b;
    localparam logic [3:0] BIT_LAST = 4'ha;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [7:0] HDR_CONTROL_ERROR = 8'h03;
    // LED output codes
    typedef enum logic [1:0] {LED_OFF, LED_ON, LED_SLOW, LED_FAST} led_code_t;
endpackage

// File: rtl/pkt_if.sv
// Decoded packet carrier between decoder and regulator
`timescale 1ns/1ns
interface pkt_if;
    logic valid;
    logic [7:0] header;
    logic [7:0] payload0;
    logic bad;
    modport dec (output valid, output header, output payload0, output bad);
    modport ctl (input valid, input header, input payload0, input bad);
endinterface

// File: rtl/packet_decoder.sv
// Bit-stream packet decoder: preamble, header, payload, checksum
`timescale 1ns/1ns
module packet_decoder (
    input wire logic clk,
    input wire logic srst,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    pkt_if.dec pkt
);
    import wpt_pkg::*;

    typedef enum {HUNT, START, BYTE} dec_state_t;
    dec_state_t state_r;
    logic [4:0] ones_r;
    logic [3:0] bit_r;
    logic [9:0] sh_r;
    logic [3:0] idx_r;
    logic [3:0] len_r;
    logic [7:0] sum_r;
    logic [7:0] hdr_r;
    logic [7:0] p0_r;
    logic [9:0] word;
    logic frame_ok;

    // Incoming frame: data LSB first, odd parity, stop bit
    assign word = {rx_bit, sh_r[9:1]};
    assign frame_ok = (^word[8:0]) && word[9];

    // Packet sequencing: preamble, header, payload, checksum
    always_ff @(posedge clk) begin
        pkt.valid <= 1'b0;
        pkt.bad <= 1'b0;
        if (srst) begin
            state_r <= HUNT;
            ones_r <= 5'h00;
            bit_r <= 4'h0;
            sh_r <= 10'h000;
            idx_r <= 4'h0;
            len_r <= 4'h0;
            sum_r <= 8'h00;
            hdr_r <= 8'h00;
            p0_r <= 8'h00;
            pkt.header <= 8'h00;
            pkt.payload0 <= 8'h00;
        end else if (rx_bit_valid) begin
            unique case (state_r)
                HUNT: begin
                    if (rx_bit) begin
                        ones_r <= (ones_r == 5'h1f) ? ones_r : ones_r + 5'h01;
                    end else begin
                        ones_r <= 5'h00;
                        if (ones_r >= PREAMBLE_MIN) begin
                            state_r <= BYTE;
                            bit_r <= BIT_FIRST;
                            idx_r <= 4'h0;
                            sum_r <= 8'h00;
                        end
                    end
                end
                START: begin
                    state_r <= rx_bit ? HUNT : BYTE;
                    bit_r <= BIT_FIRST;
                end
                BYTE: begin
                    sh_r <= word;
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == BIT_LAST) begin
                        state_r <= frame_ok ? START : HUNT;
                        idx_r <= idx_r + 4'h1;
                        sum_r <= sum_r ^ word[7:0];
                        if (idx_r == 4'h0) begin
                            hdr_r <= word[7:0];
                            len_r <= {1'b0, word[7:5]} + 4'h1;
                        end
                        if (idx_r == 4'h1) begin
                            p0_r <= word[7:0];
                        end
                        // Checksum byte closes the packet
                        if (frame_ok && idx_r != 4'h0 && idx_r == len_r + 4'h1) begin
                            state_r <= HUNT;
                            if ((sum_r ^ word[7:0]) == 8'h00) begin
                                pkt.valid <= 1'b1;
                                pkt.header <= hdr_r;
                                pkt.payload0 <= p0_r;
                            end else begin
                                pkt.bad <= 1'b1; // Mismatch dropped
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule // packet_decoder

// File: rtl/power_transmitter.sv
// Coil drive frequency regulator with supply-droop limiting and LEDs
// Overview of operation
// - Drive frequency stays within 110 kHz to 205 kHz at all times.
// - Less power means a higher frequency, more power a lower one.
// - Duty is 50% across the band and trims only once 200 kHz (HP_MIN) is reached.
// - Messages flow only from receiver to transmitter; nothing is sent back.
// - Packets decode as preamble, header, payload, then checksum.
// - A decoded control request steps the drive frequency up or down.
// - A drooping input supply makes the block step power down to keep margin.
// - LEDs show limiting in schemes 1, 2, 4, 6 and 7; schemes 3, 5 and 8 show the same as while driving.
// - A negative control error is still honoured while limiting.
// - Two bridge outputs drive the phase-shifted halves with no dead time inserted.
// - Green and red LEDs can be solid or slow blink near 1.6 s; amber only slow blinks; fast blink is never selected.
`timescale 1ns/1ns
module power_transmitter #(
    parameter int FAST_HALF = wpt_pkg::FAST_HALF_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic drive_enable,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic supply_droop,
    input wire logic [3:0] led_scheme_select,
    output logic bridge_a,
    output logic bridge_b,
    output logic [2:0] led,
    output logic supply_droop_power_limit,
    output logic [6:0] half_period,
    output logic [6:0] duty_trim
);
    import wpt_pkg::*;

    pkt_if pkt ();
    logic [6:0] hp_r;
    logic [6:0] trim_r;
    logic [6:0] on_time;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic [12:0] lim_cnt_r;
    logic lim_tick;
    logic limit_r;
    logic ce_req;
    logic ce_neg;
    logic ce_pos;
    logic step_down;
    logic step_up;
    logic [31:0] blink_cnt_r;
    logic [1:0] slow_cnt_r;
    logic fast_ph_r;
    logic slow_ph_r;
    led_code_t code [3];

    // Receive-only link: the block has no transmit path
    packet_decoder u_dec (
        .clk(clk),
        .srst(srst),
        .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit),
        .pkt(pkt)
    );

    // Control error requests, only from checksum-clean packets
    // A dropped packet raises bad alone, so it can never pass as a request
    assign ce_req = pkt.valid && !pkt.bad && pkt.header == HDR_CONTROL_ERROR;
    assign ce_neg = ce_req && pkt.payload0[7];
    assign ce_pos = ce_req && !pkt.payload0[7] && pkt.payload0 != 8'h00;

    // Negative error honoured even while limiting
    assign step_down = ce_neg || (limit_r && lim_tick);
    // Limiter owns the point: no increase while it is active
    // A step down in the same cycle always wins over a request to step up
    assign step_up = ce_pos && !limit_r && !step_down;

    // Operating point: frequency first, duty trim only at band top
    always_ff @(posedge clk) begin
        if (srst) begin
            hp_r <= HP_RESET;
            trim_r <= TRIM_RESET;
        end else if (step_down) begin
            // Higher frequency lowers power
            if (hp_r > HP_MIN) begin
                hp_r <= hp_r - 7'h01;
            end else if (trim_r < TRIM_MAX) begin
                trim_r <= trim_r + 7'h01;
            end
        end else if (step_up) begin
            // Undo duty trim before leaving the band top
            if (trim_r != 7'h00) begin
                trim_r <= trim_r - 7'h01;
            end else if (hp_r < HP_MAX) begin
                hp_r <= hp_r + 7'h01;
            end
        end
    end

    assign on_time = hp_r - trim_r;

    // Period counter over two half periods
    // Compare is >= so a half period that shrinks mid-period still wraps
    always_comb begin
        cnt_nxt = cnt_r + 7'h01;
        if (cnt_r + 7'h01 >= {hp_r[5:0], 1'b0}) begin
            cnt_nxt = 7'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !drive_enable) begin
            cnt_r <= 7'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Bridge halves, 50% each at zero trim, no dead time here
    // Gate drivers outside the block must add the switching dead time
    // Trim only shortens each on phase, so the halves can never overlap
    always_ff @(posedge clk) begin
        if (srst || !drive_enable) begin
            bridge_a <= 1'b0;
            bridge_b <= 1'b0;
        end else begin
            bridge_a <= cnt_r < on_time;
            bridge_b <= cnt_r >= hp_r && cnt_r < hp_r + on_time;
        end
    end

    // Limiter step timer
    // Free-running, so the step rate does not depend on when droop began
    always_ff @(posedge clk) begin
        if (srst || lim_tick) begin
            lim_cnt_r <= 13'h0000;
        end else begin
            lim_cnt_r <= lim_cnt_r + 13'h0001;
        end
    end
    assign lim_tick = lim_cnt_r == 13'(LIMIT_STEP_CYC - 1);

    // Limiting active while droop seen; released on the next limiter tick with droop low
    // The releasing tick still takes one last step down; requests win it back
    always_ff @(posedge clk) begin
        if (srst) begin
            limit_r <= 1'b0;
        end else if (supply_droop) begin
            limit_r <= 1'b1;
        end else if (lim_tick) begin
            limit_r <= 1'b0;
        end
    end

    // Blink phases: fast toggles each half, slow every fourth toggle
    // One shared divider keeps slow and fast blinking in step
    always_ff @(posedge clk) begin
        if (srst) begin
            blink_cnt_r <= 32'h0;
            slow_cnt_r <= 2'h0;
            fast_ph_r <= 1'b0;
            slow_ph_r <= 1'b0;
        end else if (blink_cnt_r == 32'(FAST_HALF - 1)) begin
            blink_cnt_r <= 32'h0;
            fast_ph_r <= !fast_ph_r;
            slow_cnt_r <= slow_cnt_r + 2'h1;
            if (slow_cnt_r == 2'(SLOW_PER_FAST - 1)) begin
                slow_ph_r <= !slow_ph_r;
            end
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    // LED scheme: green, red, amber codes per state
    // Scheme codes outside 1 to 8 leave every LED dark
    always_comb begin
        code[0] = LED_OFF;
        code[1] = LED_OFF;
        code[2] = LED_OFF;
        if (limit_r) begin
            // Limiting indication
            unique case (led_scheme_select)
                4'h1, 4'h2: begin
                    code[0] = LED_SLOW;
                    code[1] = LED_SLOW;
                end
                4'h3: code[0] = LED_ON;
                4'h4: code[1] = LED_SLOW;
                4'h5, 4'h8: code[1] = LED_ON;
                4'h6, 4'h7: code[2] = LED_SLOW;
                default: code[0] = LED_OFF;
            endcase
        end else if (drive_enable) begin
            unique case (led_scheme_select)
                4'h1, 4'h2, 4'h6, 4'h7: code[0] = LED_SLOW;
                4'h3, 4'h4: code[0] = LED_ON;
                4'h5, 4'h8: code[1] = LED_ON;
                default: code[0] = LED_OFF;
            endcase
        end else if (led_scheme_select == 4'h2) begin
            code[0] = LED_ON;
            code[1] = LED_ON;
        end
    end

    // LED pins from flops
    generate
        for (genvar i = 0; i < 3; i++) begin : g_led
            always_ff @(posedge clk) begin
                if (srst) begin
                    led[i] <= 1'b0;
                end else begin
                    led[i] <= code[i] == LED_ON || (code[i] == LED_SLOW && slow_ph_r)
                        || (code[i] == LED_FAST && fast_ph_r);
                end
            end
        end
    endgenerate

    // Status outputs
    assign supply_droop_power_limit = limit_r;
    assign half_period = hp_r;
    assign duty_trim = trim_r;
endmodule // power_transmitter

// File: testbench/power_transmitter_asserts.sv
// Concurrent checks on the power transmitter ports
`timescale 1ns/1ns
module power_transmitter_asserts #(
    parameter int FAST_HALF = wpt_pkg::FAST_HALF_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic drive_enable,
    input wire logic supply_droop,
    input wire logic [3:0] led_scheme_select,
    input wire logic bridge_a,
    input wire logic bridge_b,
    input wire logic [2:0] led,
    input wire logic supply_droop_power_limit,
    input wire logic [6:0] half_period,
    input wire logic [6:0] duty_trim
);
    import wpt_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Operating point limits
    a_hp_band: assert property (half_period >= HP_MIN && half_period <= HP_MAX)
        else $error("half period outside band");
    a_trim_max: assert property (duty_trim <= TRIM_MAX)
        else $error("trim above limit");
    a_trim_top: assert property (duty_trim != 7'h00 |-> half_period == HP_MIN)
        else $error("trim below band top");
    // Frequency moves one step at a time
    a_hp_step: assert property ($changed(half_period) |->
        (half_period - $past(half_period) == 7'h01 || $past(half_period) - half_period == 7'h01))
        else $error("half period jumped");
    // Bridge halves
    a_no_overlap: assert property (!(bridge_a && bridge_b))
        else $error("both bridge halves high");
    a_drive_off: assert property (!drive_enable |=> !bridge_a && !bridge_b)
        else $error("bridge driven while disabled");
    // Droop limiter
    a_limit_sets: assert property (supply_droop |=> supply_droop_power_limit)
        else $error("limit not set on droop");
    a_no_raise: assert property (supply_droop_power_limit |=>
        half_period <= $past(half_period) && duty_trim >= $past(duty_trim))
        else $error("power raised while limiting");
    a_led_limit: assert property (supply_droop_power_limit && led_scheme_select == 4'h1 |=>
        led[0] == led[1] && !led[2])
        else $error("limit indication wrong");
endmodule // power_transmitter_asserts

bind power_transmitter power_transmitter_asserts #(.FAST_HALF(FAST_HALF))
    u_power_transmitter_asserts (.clk(clk), .srst(srst), .drive_enable(drive_enable),
    .supply_droop(supply_droop), .led_scheme_select(led_scheme_select),
    .bridge_a(bridge_a), .bridge_b(bridge_b), .led(led),
    .supply_droop_power_limit(supply_droop_power_limit),
    .half_period(half_period), .duty_trim(duty_trim));

// File: testbench/rx_model.sv
// Receiver model sending control error packets bit by bit
`timescale 1ns/1ns
module rx_model (
    input wire logic clk,
    output logic rx_bit_valid,
    output logic rx_bit
);
    initial begin
        rx_bit_valid = 1'b0;
        rx_bit = 1'b0;
    end
    // One bit per two cycles; idle line shows inverse of last bit
    task automatic put(input logic b);
        @(negedge clk);
        rx_bit_valid = 1'b1;
        rx_bit = b;
        @(negedge clk);
        rx_bit_valid = 1'b0;
        rx_bit = ~b;
    endtask
    // Start, data LSB first, odd parity, stop
    task automatic put_byte(input logic [7:0] d);
        put(1'b0);
        for (int i = 0; i < 8; i++) put(d[i]);
        put(~^d);
        put(1'b1);
    endtask
    // Traffic only toward the block; bad flips the checksum
    task automatic send_ce(input logic [7:0] ce, input logic bad);
        for (int i = 0; i < 11; i++) put(1'b1);
        put_byte(8'h03);
        put_byte(ce);
        put_byte(8'h03 ^ ce ^ {7'h00, bad});
    endtask
endmodule // rx_model

// File: testbench/tb_top.sv
// Self-checking bench for the power transmitter
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
    import wpt_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic drive_enable = 1'b0;
    logic supply_droop = 1'b0;
    logic [3:0] led_scheme_select = 4'h1;
    logic rx_bit_valid, rx_bit, bridge_a, bridge_b, supply_droop_power_limit;
    logic [2:0] led;
    logic [6:0] half_period, duty_trim;
    int fail_count = 0;
    int cmp_count = 0;
    always #50 clk = ~clk;
    power_transmitter #(.FAST_HALF(10)) u_power_transmitter (.clk(clk), .srst(srst),
        .drive_enable(drive_enable), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .supply_droop(supply_droop), .led_scheme_select(led_scheme_select),
        .bridge_a(bridge_a), .bridge_b(bridge_b), .led(led),
        .supply_droop_power_limit(supply_droop_power_limit),
        .half_period(half_period), .duty_trim(duty_trim));
    rx_model u_rx_model (.clk(clk), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));
    // Verdict and end of run
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait for a half period change (0) or a limit level (1)
    task automatic wait_sig(input bit lim, input logic [6:0] v);
        for (int i = 0; i < 4200; i++) begin
            @(negedge clk);
            if (lim ? supply_droop_power_limit === v[0] : half_period !== v) return;
        end
        fail_count++;
        $display("unexpected timeout waiting");
        finish_test();
    endtask
    // Cycles a watched output stays at v
    task automatic width(input bit sel, input logic v, output int n);
        n = 0;
        while ((sel ? led[0] : bridge_a) === v && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n == 300) begin
            fail_count++;
            $display("unexpected %s width exp below 300 got %0d", sel ? "led" : "bridge", n);
            finish_test();
        end
    endtask
    // Full high and low phases of bridge A
    task automatic duty(input int hi, input int lo);
        int n;
        width(0, 1'b1, n);
        width(0, 1'b0, n);
        width(0, 1'b1, n);
        `CHK("bridge high", hi, n)
        width(0, 1'b0, n);
        `CHK("bridge low", lo, n)
    endtask
    // One packet, then the operating point two edges on
    task automatic ce(input logic [7:0] v, input logic bad, input logic [6:0] hp,
        input logic [6:0] tr);
        u_rx_model.send_ce(v, bad);
        repeat (2) @(negedge clk);
        `CHK("half period", hp, half_period)
        `CHK("duty trim", tr, duty_trim)
    endtask
    task automatic t_reset();
        `CHK("half period", HP_RESET, half_period)
        `CHK("duty trim", TRIM_RESET, duty_trim)
        `CHK("limit", 1'b0, supply_droop_power_limit)
        `CHK("led", 3'h0, led)
        drive_enable = 1'b1;
        $display("test reset done");
    endtask
    task automatic t_ce();
        ce(8'hff, 1'b0, 7'h2c, 7'h00);
        ce(8'h01, 1'b0, 7'h2d, 7'h00);
        ce(8'h01, 1'b0, 7'h2d, 7'h00);
        ce(8'hff, 1'b1, 7'h2d, 7'h00);
        duty(45, 45);
        $display("test control done");
    endtask
    task automatic t_limit();
        int n;
        supply_droop = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("limit", 1'b1, supply_droop_power_limit)
        width(1, 1'b0, n);
        width(1, 1'b1, n);
        width(1, 1'b0, n);
        `CHK("slow blink half", 40, n)
        led_scheme_select = 4'h5;
        repeat (2) @(negedge clk);
        `CHK("led red solid", 3'h2, led)
        led_scheme_select = 4'h3;
        repeat (2) @(negedge clk);
        `CHK("led green solid", 3'h1, led)
        led_scheme_select = 4'h1;
        wait_sig(0, 7'h2d);
        `CHK("half period", 7'h2c, half_period)
        ce(8'hff, 1'b0, 7'h2b, 7'h00);
        ce(8'h01, 1'b0, 7'h2b, 7'h00);
        supply_droop = 1'b0;
        wait_sig(1, 7'h00);
        `CHK("limit", 1'b0, supply_droop_power_limit)
        `CHK("half period", 7'h2a, half_period)
        $display("test limit done");
    endtask
    task automatic t_floor();
        for (int i = 1; i <= 17; i++) ce(8'hff, 1'b0, 7'(42 - i), 7'h00);
        for (int i = 1; i <= 21; i++) ce(8'hff, 1'b0, HP_MIN, 7'(i > 20 ? 20 : i));
        duty(5, 45);
        ce(8'h01, 1'b0, HP_MIN, 7'h13);
        drive_enable = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("bridge a", 1'b0, bridge_a)
        `CHK("bridge b", 1'b0, bridge_b)
        led_scheme_select = 4'h2;
        repeat (2) @(negedge clk);
        `CHK("led standby", 3'h3, led)
        $display("test floor done");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        t_reset();
        t_ce();
        t_limit();
        t_floor();
        finish_test();
    end
endmodule // tb_top
